// [verilog/peiu_top.sv]
// Behaviour
// - eight selectable pin channels, each edge or level sensitive
// - each pin channel drives its own request line
// - edge channels trigger on rising, falling or both edges
// - level channels are active high or active low
// - pin channel conditions raise wake while in low power
// - pattern engine combines levels and transitions of the eight channel pins
// - each product term has its own request line
// - optional receive-event pulse when a pattern match starts with no term matching the cycle before
// - pattern matches never raise wake
// - each channel picks any pin of ports 0 and 1 by index
// - registers answer on the bus with no wait state
// - two independent group interrupt blocks
// - per-pin enable and polarity for each group block
// - group output level or edge triggered
// - group combines enabled inputs by OR or AND
// - group wakes first, request asserted only after low power ends
// - writing one to group status bit clears its request
// - group matches raise wake while in low power
//
// Chosen here: the placing of the registers and register access over APB.
`include "peiu_map.svh"
`default_nettype none
module peiu_top #(
  parameter int NPIN = 64,
  parameter int NCH  = 8,
  parameter int NTRM = 8
) (
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [7:0]      paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire logic [NPIN-1:0] pin_in,
  input  wire logic            low_power,
  output logic      [NCH-1:0]  pin_irq,
  output logic      [NTRM-1:0] term_irq,
  output logic                 processor_receive_event_pulse,
  output logic      [1:0]      grp_irq,
  output logic                 wake_req
);
  localparam int SW = $clog2(NPIN);

  function automatic logic pick(input logic [NPIN-1:0] v, input logic [7:0] idx);
    pick = v[idx[SW-1:0]];
  endfunction

  function automatic logic cond_ok(input logic [1:0] c, input logic lv,
                                   input logic r, input logic f);
    case (peiu_pkg::peiu_cond_t'(c))
      peiu_pkg::PEIU_C_HIGH: cond_ok = lv;
      peiu_pkg::PEIU_C_LOW:  cond_ok = ~lv;
      peiu_pkg::PEIU_C_RISE: cond_ok = r;
      peiu_pkg::PEIU_C_FALL: cond_ok = f;
      default:               cond_ok = 1'b0;
    endcase
  endfunction

  logic [31:0]     sela_r, selb_r, pmctl_r;
  logic [NCH-1:0]  mode_r, rise_r, fall_r, lvlhi_r, pend_r, pend_nxt;
  logic [31:0]     term_r [NTRM];
  logic [31:0]     gctl_r [2];
  logic [31:0]     gcfg_r [8];
  logic [NPIN-1:0] sync1_r, sync2_r;
  logic [NCH-1:0]  ch_now, ch_prev_r, ch_rise, ch_fall, edge_hit, lvl_hit;
  logic [NTRM-1:0] match;
  logic            any_prev_r;
  logic [1:0]      gm, gm_prev_r, ghit, gstat_nxt;
  logic [31:0]     rd_nxt;
  logic            rd_ok;

  wire setup  = psel & ~penable;
  wire wr_en  = psel & penable & pready & pwrite;
  wire pm_en  = pmctl_r[`PEIU_PM_EN];

  // registered answer: setup phase prepares, access phase completes at once
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `PEIU_RST_REG;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~rd_ok;
      prdata  <= (setup & ~pwrite & rd_ok) ? rd_nxt : 32'h0000_0000;
    end
  end

  always_comb begin
    rd_nxt = 32'h0000_0000;
    rd_ok  = 1'b1;
    if (paddr >= `PEIU_A_TERM0 && paddr <= `PEIU_A_TERM7 && paddr[1:0] == 2'b00)
      rd_nxt = term_r[paddr[4:2]];
    else if (paddr >= `PEIU_A_GBASE && paddr <= `PEIU_A_GLAST && paddr[1:0] == 2'b00)
      rd_nxt = gcfg_r[3'(paddr[5:2] - 4'h2)];
    else begin
      case (paddr)
        `PEIU_A_SELA:  rd_nxt = sela_r;
        `PEIU_A_SELB:  rd_nxt = selb_r;
        `PEIU_A_MODE:  rd_nxt = 32'(mode_r);
        `PEIU_A_RISE:  rd_nxt = 32'(rise_r);
        `PEIU_A_FALL:  rd_nxt = 32'(fall_r);
        `PEIU_A_LVLHI: rd_nxt = 32'(lvlhi_r);
        `PEIU_A_PEND:  rd_nxt = 32'(pend_r);
        `PEIU_A_PMCTL: rd_nxt = pmctl_r;
        `PEIU_A_GCTL0: rd_nxt = gctl_r[0];
        `PEIU_A_GCTL1: rd_nxt = gctl_r[1];
        `PEIU_A_STAT:  rd_nxt = {22'h0, gm, ch_now};
        default:       rd_ok  = 1'b0;
      endcase
    end
  end

  // configuration registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sela_r  <= `PEIU_RST_REG;
      selb_r  <= `PEIU_RST_REG;
      pmctl_r <= `PEIU_RST_REG;
      mode_r  <= '0;
      rise_r  <= '0;
      fall_r  <= '0;
      lvlhi_r <= '0;
    end else if (wr_en) begin
      case (paddr)
        `PEIU_A_SELA:  sela_r  <= pwdata;
        `PEIU_A_SELB:  selb_r  <= pwdata;
        `PEIU_A_MODE:  mode_r  <= pwdata[NCH-1:0];
        `PEIU_A_RISE:  rise_r  <= pwdata[NCH-1:0];
        `PEIU_A_FALL:  fall_r  <= pwdata[NCH-1:0];
        `PEIU_A_LVLHI: lvlhi_r <= pwdata[NCH-1:0];
        `PEIU_A_PMCTL: pmctl_r <= {30'h0, pwdata[1:0]};
        default:       ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    for (int k = 0; k < NTRM; k++) begin
      if (!rst_n)
        term_r[k] <= `PEIU_RST_REG;
      else if (wr_en && paddr == `PEIU_A_TERM0 + 8'(4 * k))
        term_r[k] <= {8'h00, pwdata[23:0]};
    end
    for (int k = 0; k < 8; k++) begin
      if (!rst_n)
        gcfg_r[k] <= `PEIU_RST_REG;
      else if (wr_en && paddr == `PEIU_A_GBASE + 8'(4 * k))
        gcfg_r[k] <= pwdata;
    end
  end

  // every pin is synchronised, so channel and group logic share one copy
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_r   <= '0;
      sync2_r   <= '0;
      ch_prev_r <= '0;
    end else begin
      sync1_r   <= pin_in;
      sync2_r   <= sync1_r;
      ch_prev_r <= ch_now;
    end
  end

  // changing a selection may itself look like an edge; clear pending after it
  genvar i;
  generate
    for (i = 0; i < NCH; i++) begin : g_ch
      wire [7:0] sel = (i < 4) ? sela_r[8*(i%4) +: 8] : selb_r[8*(i%4) +: 8];
      assign ch_now[i]   = pick(sync2_r, sel);
      assign ch_rise[i]  = ch_now[i] & ~ch_prev_r[i];
      assign ch_fall[i]  = ~ch_now[i] & ch_prev_r[i];
      assign edge_hit[i] = ~mode_r[i] & ((ch_rise[i] & rise_r[i]) |
                                         (ch_fall[i] & fall_r[i]));
      assign lvl_hit[i]  = mode_r[i] & rise_r[i] & (ch_now[i] == lvlhi_r[i]);
      // set wins over a clear in the same cycle
      assign pend_nxt[i] = edge_hit[i] |
                           (pend_r[i] & ~(wr_en && paddr == `PEIU_A_PEND && pwdata[i]));
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pend_r  <= '0;
      pin_irq <= '0;
    end else begin
      pend_r  <= pend_nxt;
      for (int k = 0; k < NCH; k++)
        pin_irq[k] <= mode_r[k] ? lvl_hit[k] : pend_nxt[k];
    end
  end

  // product terms look only at the current cycle's levels and edges
  genvar t;
  generate
    for (t = 0; t < NTRM; t++) begin : g_trm
      logic [NCH-1:0] ok;
      wire  [NCH-1:0] care = term_r[t][`PEIU_TERM_CARE +: NCH];
      for (genvar j = 0; j < NCH; j++) begin : g_in
        assign ok[j] = cond_ok(term_r[t][`PEIU_TERM_COND + 2*j +: 2],
                               ch_now[j], ch_rise[j], ch_fall[j]);
      end
      assign match[t] = pm_en & (|care) & (&(ok | ~care));
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      term_irq   <= '0;
      processor_receive_event_pulse <= 1'b0;
      any_prev_r <= 1'b0;
    end else begin
      term_irq   <= match;
      any_prev_r <= |match;
      processor_receive_event_pulse <= pmctl_r[`PEIU_PM_PROCESSOR_RECEIVE_EVENT] & (|match) & ~any_prev_r;
    end
  end

  // group blocks: enable lo/hi then polarity lo/hi, four words each
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_grp
      wire [63:0] ena = {gcfg_r[4*g+1], gcfg_r[4*g]};
      wire [63:0] pol = {gcfg_r[4*g+3], gcfg_r[4*g+2]};
      wire [NPIN-1:0] act = sync2_r ~^ pol[NPIN-1:0];
      wire [NPIN-1:0] en  = ena[NPIN-1:0];
      wire g_and = gctl_r[g][`PEIU_G_AND];
      assign gm[g] = g_and ? ((|en) & (&(act | ~en))) : (|(act & en));
      assign ghit[g] = gctl_r[g][`PEIU_G_LEVEL] ? gm[g] : (gm[g] & ~gm_prev_r[g]);
      assign gstat_nxt[g] = ghit[g] | (gctl_r[g][`PEIU_G_STAT] &
        ~(wr_en && paddr == `PEIU_A_GCTL0 + 8'(4 * g) && pwdata[`PEIU_G_STAT]));
    end
  endgenerate

  always_ff @(posedge clk) begin
    for (int k = 0; k < 2; k++) begin
      if (!rst_n)
        gctl_r[k] <= `PEIU_RST_REG;
      else if (wr_en && paddr == `PEIU_A_GCTL0 + 8'(4 * k))
        gctl_r[k] <= {29'h0, pwdata[2:1], gstat_nxt[k]};
      else
        gctl_r[k][`PEIU_G_STAT] <= gstat_nxt[k];
    end
  end

  // request held back while asleep so wake always comes first
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gm_prev_r <= '0;
      grp_irq   <= '0;
      wake_req  <= 1'b0;
    end else begin
      gm_prev_r <= gm;
      grp_irq   <= gstat_nxt & {2{~low_power}};
      wake_req  <= low_power & ((|gm) | (|edge_hit) | (|lvl_hit));
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_access;
    psel && penable && pready;
  endsequence

  apb_ready_a: assert property (s_setup |=> s_access or !psel)
    else $error("bus access not answered at once");
  apb_err_a: assert property (pready |-> $past(psel) && !$past(penable))
    else $error("ready without a setup phase");
  edge_pend_a: assert property (edge_hit[0] |=> pin_irq[0])
    else $error("edge did not raise channel 0");
  pend_hold_a: assert property (pin_irq[0] && !mode_r[0] && !wr_en |=> pin_irq[0])
    else $error("pending edge lost without clear");
  level_follow_a: assert property (mode_r[2] && $stable(mode_r[2])
                                   |=> pin_irq[2] == $past(lvl_hit[2]))
    else $error("level channel not following pin");
  processor_receive_event_once_a: assert property (processor_receive_event_pulse |=> !processor_receive_event_pulse)
    else $error("receive event longer than one cycle");
  pm_nowake_a: assert property (!low_power |=> !wake_req)
    else $error("wake raised while awake");
  grp_hold_a: assert property (low_power |=> grp_irq == 2'b00)
    else $error("group request during low power");
  grp_wake_a: assert property (low_power && gm[0] |=> wake_req)
    else $error("group match did not wake");
  grp_clear_a: assert property (wr_en && paddr == `PEIU_A_GCTL0 && pwdata[0] && !ghit[0]
                                |=> !grp_irq[0])
    else $error("group 0 request not cleared");

  // channel 0 armed for rising edges and sees one
  sequence s_ch0_rise;
    ch_rise[0] && rise_r[0] && !mode_r[0];
  endsequence

  // channel 0 idle with nothing pending
  sequence s_ch0_quiet;
    !mode_r[0] && !pend_r[0] && !edge_hit[0];
  endsequence

  // group b in level mode and matching while awake
  sequence s_grp1_level;
    gctl_r[1][`PEIU_G_LEVEL] && gm[1] && !low_power;
  endsequence

  // asleep while some edge channel fires
  sequence s_sleep_hit;
    low_power && (edge_hit != '0);
  endsequence

  // pattern engine switched off
  sequence s_pm_off;
    !pmctl_r[`PEIU_PM_EN];
  endsequence

  apb_once_a: assert property (pready
                               |=> !pready)
    else $error("ready held past one cycle");

  apb_errq_a: assert property (pslverr
                               |-> pready)
    else $error("error without ready");

  apb_wrzero_a: assert property (pready && pwrite
                                 |-> prdata == 32'h0000_0000)
    else $error("read data shown during a write");

  rise_pend_a: assert property (s_ch0_rise
                                |=> pin_irq[0] && pend_r[0])
    else $error("rising edge not latched on channel 0");

  chan_own_a: assert property (s_ch0_quiet
                               |=> !pin_irq[0])
    else $error("channel 0 raised by another channel");

  fall_pend_a: assert property (ch_fall[1] && fall_r[1] && !mode_r[1]
                                |=> pin_irq[1])
    else $error("falling edge not latched on channel 1");

  wake_pin_a: assert property (s_sleep_hit
                               |=> wake_req)
    else $error("pin channel did not wake");

  term_own_a: assert property (match[0]
                               |=> term_irq[0])
    else $error("term 0 match not raised");

  pm_off_a: assert property (s_pm_off
                             |=> term_irq == '0)
    else $error("term request while engine off");

  processor_receive_event_off_a: assert property (!pmctl_r[`PEIU_PM_PROCESSOR_RECEIVE_EVENT]
                               |=> !processor_receive_event_pulse)
    else $error("receive event while disabled");

  sync_lag_a: assert property ($past(rst_n)
                               |-> sync1_r == $past(pin_in))
    else $error("pin sampler lost a cycle");

  grp_lvl_a: assert property (s_grp1_level
                              |=> grp_irq[1])
    else $error("level group b not requesting");

  grp_empty_a: assert property (gctl_r[0][`PEIU_G_AND] && gcfg_r[0] == '0 && gcfg_r[1] == '0
                                |-> !gm[0])
    else $error("and group matched with no pins");

  quiet_nowake_a: assert property (low_power && edge_hit == '0 && lvl_hit == '0 && gm == '0
                                   |=> !wake_req)
    else $error("wake raised with no pin or group cause");
endmodule
`default_nettype wire

// [shared/peiu_map.svh]
`ifndef PEIU_MAP_SVH
`define PEIU_MAP_SVH
`define PEIU_A_SELA   8'h00
`define PEIU_A_SELB   8'h04
`define PEIU_A_MODE   8'h08
`define PEIU_A_RISE   8'h0c
`define PEIU_A_FALL   8'h10
`define PEIU_A_LVLHI  8'h14
`define PEIU_A_PEND   8'h18
`define PEIU_A_PMCTL  8'h1c
`define PEIU_A_TERM0  8'h20
`define PEIU_A_TERM7  8'h3c
`define PEIU_A_GCTL0  8'h40
`define PEIU_A_GCTL1  8'h44
`define PEIU_A_GBASE  8'h48
`define PEIU_A_GLAST  8'h64
`define PEIU_A_STAT   8'h68
`define PEIU_SEL_W    8
`define PEIU_PM_EN    0
`define PEIU_PM_PROCESSOR_RECEIVE_EVENT  1
`define PEIU_TERM_CARE 0
`define PEIU_TERM_COND 8
`define PEIU_G_STAT   0
`define PEIU_G_AND    1
`define PEIU_G_LEVEL  2
`define PEIU_RST_REG  32'h0000_0000
`endif

// [shared/peiu_pkg.sv]
`default_nettype none
package peiu_pkg;
  typedef enum logic [1:0] {
    PEIU_C_HIGH = 2'b00,
    PEIU_C_LOW  = 2'b01,
    PEIU_C_RISE = 2'b10,
    PEIU_C_FALL = 2'b11
  } peiu_cond_t;
endpackage
`default_nettype wire

// [testbench/peiu_pins.sv]
`default_nettype none
module peiu_pins (
  input  wire logic        clk,
  output logic      [63:0] pin_in,
  output logic             low_power
);
  timeunit 1ns;
  timeprecision 1ps;
  // pads start low and awake; levels change just after an edge, never mid-cycle
  initial begin
    pin_in    = 64'h0;
    low_power = 1'b0;
  end
  // any pin of ports 0 and 1 can be moved
  task automatic set_pin(input int idx, input logic v);
    @(posedge clk);
    pin_in[idx] <= v;
  endtask
  // sleep state of the part
  task automatic set_lp(input logic v);
    @(posedge clk);
    low_power <= v;
  endtask
endmodule
`default_nettype wire

// [testbench/tb.sv]
`include "peiu_map.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, processor_receive_event_pulse, wake_req;
  logic [7:0]  paddr, pin_irq, term_irq;
  logic [31:0] pwdata, prdata, rd;
  logic [63:0] pin_in;
  logic        low_power, er;
  logic [1:0]  grp_irq;
  int          n_fail, check_count;
  peiu_top dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .low_power(low_power), .pin_irq(pin_irq), .term_irq(term_irq),
    .processor_receive_event_pulse(processor_receive_event_pulse), .grp_irq(grp_irq), .wake_req(wake_req));
  peiu_pins pins (.clk(clk), .pin_in(pin_in), .low_power(low_power));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    if (i == 20) begin
      n_fail++;
      complete_run();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // pin changes show at pin_irq three edges on; six covers it with margin
  task automatic settle();
    repeat (6) @(posedge clk);
  endtask
  task automatic t_regs();
    apb(1'b0, `PEIU_A_PEND, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, er}, 32'h0);
    apb(1'b0, 8'h80, 32'h0);
    chk({31'h0, er}, 32'h1);
    $display("test regs done");
  endtask
  task automatic t_edge();
    apb(1'b1, `PEIU_A_SELA, 32'h0007_2805);
    apb(1'b1, `PEIU_A_FALL, 32'h2);
    apb(1'b1, `PEIU_A_RISE, 32'h1);
    apb(1'b1, `PEIU_A_PEND, 32'hff);
    pins.set_pin(5, 1'b1);
    pins.set_pin(40, 1'b1);
    settle();
    chk({24'h0, pin_irq}, 32'h01);
    pins.set_pin(5, 1'b0);
    pins.set_pin(40, 1'b0);
    settle();
    chk({24'h0, pin_irq}, 32'h03);
    apb(1'b1, `PEIU_A_PEND, 32'h1);
    settle();
    chk({24'h0, pin_irq}, 32'h02);
    apb(1'b1, `PEIU_A_PEND, 32'h2);
    $display("test edge done");
  endtask
  task automatic t_level();
    apb(1'b1, `PEIU_A_MODE, 32'h4);
    apb(1'b1, `PEIU_A_RISE, 32'h5);
    settle();
    chk({24'h0, pin_irq}, 32'h04);
    pins.set_pin(7, 1'b1);
    settle();
    chk({24'h0, pin_irq}, 32'h00);
    $display("test level done");
  endtask
  task automatic t_group();
    apb(1'b1, `PEIU_A_RISE, 32'h0);
    apb(1'b1, `PEIU_A_GBASE, 32'h200);
    apb(1'b1, `PEIU_A_GBASE + 8'h08, 32'h200);
    pins.set_lp(1'b1);
    pins.set_pin(9, 1'b1);
    settle();
    chk({30'h0, grp_irq}, 32'h0);
    chk({31'h0, wake_req}, 32'h1);
    pins.set_lp(1'b0);
    settle();
    chk({30'h0, grp_irq}, 32'h1);
    apb(1'b1, `PEIU_A_GCTL0, 32'h1);
    settle();
    chk({30'h0, grp_irq}, 32'h0);
    pins.set_pin(9, 1'b0);
    $display("test group done");
  endtask
  task automatic t_match();
    int i;
    int seen;
    seen = 0;
    apb(1'b1, `PEIU_A_TERM0, 32'h0000_0201);
    apb(1'b1, `PEIU_A_PMCTL, 32'h3);
    pins.set_lp(1'b1);
    pins.set_pin(5, 1'b1);
    for (i = 0; i < 8; i++) begin
      @(posedge clk);
      if (processor_receive_event_pulse === 1'b1 && term_irq === 8'h01) seen++;
    end
    chk(seen, 32'h1);
    chk({31'h0, wake_req}, 32'h0);
    pins.set_lp(1'b0);
    $display("test match done");
  endtask
  task automatic t_and();
    apb(1'b1, `PEIU_A_GCTL1, 32'h6);
    apb(1'b1, `PEIU_A_GBASE + 8'h10, 32'h60);
    apb(1'b1, `PEIU_A_GBASE + 8'h18, 32'h60);
    settle();
    chk({30'h0, grp_irq}, 32'h0);
    pins.set_pin(6, 1'b1);
    settle();
    chk({30'h0, grp_irq}, 32'h2);
    pins.set_pin(6, 1'b0);
    settle();
    chk({30'h0, grp_irq}, 32'h2);
    apb(1'b1, `PEIU_A_GCTL1, 32'h7);
    settle();
    chk({30'h0, grp_irq}, 32'h0);
    $display("test and done");
  endtask
  initial begin
    n_fail = 0;
    check_count = 0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_edge();
    t_level();
    t_group();
    t_match();
    t_and();
    complete_run();
  end
endmodule
`default_nettype wire
